// file: src/ttc_pkg.sv
// Constants, types and behaviour list of the tape transport control core
// Function
// - Write start: motion, gap delay, first word request
// - 7-track: three 6-bit characters, counter steps each
// - First character takes the word's high bits
// - Last character of word raises word request
// - Count zero: write check character, await end
// - End of record: decel delay, done, stop
// - Read shifts characters in, requests per word
// - Four skip flags; done/error request interrupt
// - One bit reverses track state, zero holds
// - Track flip-flop toggles only on one bits
// - Clearing write buffer emits longitudinal check
// - First transition starts skew, then sample all
// - Command load gives clear then load pulse
// - Clear pulse when idle clears everything
// - Load pulse copies accumulator into command
// - Loaded command selects transport at once
// - Skip tests for control and transport ready
// - Start sets go only for legal command
// - Load while busy, not done, is illegal
// - 9-track: two characters per word
package ttc_pkg;

  // Clock rate and documented timing
  localparam int CLK_MHZ         = 10;
  localparam int CHAR_PERIOD_NS  = 27778;  // 36 kHz character rate
  localparam int SKEW_DELAY_NS   = 8000;   // Read deskew window
  localparam int IRG_DELAY_US    = 8000;   // Interrecord gap delay
  localparam int DECEL_DELAY_US  = 8000;   // Deceleration delay

  // Derived cycle counts
  localparam logic [8:0]  CHAR_CYC  = 9'(CHAR_PERIOD_NS * CLK_MHZ / 1000);
  localparam logic [7:0]  SKEW_CYC  = 8'((SKEW_DELAY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [19:0] IRG_DEF   = 20'(IRG_DELAY_US * CLK_MHZ);
  localparam logic [19:0] DECEL_DEF = 20'(DECEL_DELAY_US * CLK_MHZ);
  localparam logic [1:0]  EOR_SPACE = 2'h3;  // Last index of the 4-character space

  // Register offsets (word index on the plain port)
  localparam logic [2:0] OFS_LOAD_CMD  = 3'h0;  // Write: two-pulse load; read: command
  localparam logic [2:0] OFS_START     = 3'h1;  // Write: start motion
  localparam logic [2:0] OFS_CLR_FLAGS = 3'h2;  // Write: clear flags; when go is low, clear all
  localparam logic [2:0] OFS_STATUS    = 3'h3;  // Read: status
  localparam logic [2:0] OFS_SKIP      = 3'h4;  // Read: skip flags

  // Status bit positions
  localparam int ST_ERR_BIT   = 0;
  localparam int ST_ILL_BIT   = 1;
  localparam int ST_LATE_BIT  = 2;
  localparam int ST_DONE_BIT  = 3;
  localparam int ST_NINE_BIT  = 4;
  localparam int ST_CC_LO_BIT = 5;
  localparam int ST_CC_HI_BIT = 6;
  localparam int ST_GO_BIT    = 7;
  localparam int ST_LAST_BIT  = 8;

  // Skip bit positions
  localparam int SK_DONE_BIT = 0;
  localparam int SK_TUR_BIT  = 1;
  localparam int SK_TCR_BIT  = 2;
  localparam int SK_ERR_BIT  = 3;

  // Function and density codes
  localparam logic [2:0] FN_READ  = 3'h2;
  localparam logic [2:0] FN_WRITE = 3'h4;
  localparam logic [1:0] DENS_800 = 2'h3;

  // Command register layout, twelve bits
  typedef struct packed {
    logic       spare;
    logic       int_en;
    logic       nine_trk;
    logic       par_even;
    logic [1:0] density;
    logic [2:0] unit;
    logic [2:0] func;
  } ttc_cmd_type;

  localparam ttc_cmd_type CMD_RST = 12'h000;

  // Signals toward the transport bus
  typedef struct packed {
    logic       move_fwd;
    logic       write_en;
    logic       rec_pulse;
    logic [2:0] unit_sel;
    logic [8:0] wr_track;
  } ttc_tape_out_type;

endpackage : ttc_pkg

// file: src/ttc_core.sv
// Tape transport control core: command, flags, character sequencing and NRZ write/read
//
// Chosen here: the register addresses and the plain strobed port.
module ttc_core #(
  parameter logic [19:0] IRG_DELAY_CYC   = ttc_pkg::IRG_DEF,
  parameter logic [19:0] DECEL_DELAY_CYC = ttc_pkg::DECEL_DEF
) (
  // Clock and reset
  input  logic                      ref_clk_i,
  input  logic                      rst_n_i,
  // Register port
  input  logic [2:0]                reg_addr_i,
  input  logic [17:0]               reg_wdata_i,
  input  logic                      reg_we_i,
  input  logic                      reg_re_i,
  output logic [17:0]               reg_rdata_o,
  // Interrupt request
  output logic                      irq_o,
  // Data channel
  output logic                      dch_req_o,
  input  logic                      dch_ack_i,
  input  logic [17:0]               dch_wdata_i,
  output logic [17:0]               dch_rdata_o,
  input  logic                      wc_ovf_i,
  // Transport bus
  input  logic                      trp_ready_i,
  input  logic                      eor_i,
  input  logic [8:0]                rd_pulse_i,
  output ttc_pkg::ttc_tape_out_type tape_o
);
  import ttc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_GAP, ST_WRITE, ST_WR_EOR, ST_WAIT_EOR, ST_READ, ST_DECEL
  } ttc_state_type;

  // True when the character counter stands on the last character of a word
  function automatic logic ttc_cc_last(input logic [1:0] cc, input logic nine);
    ttc_cc_last = nine ? (cc == 2'h1) : (cc == 2'h2);
  endfunction : ttc_cc_last

  // Pin synchronisers
  logic [10:0]   sync1_q;       // First stage, read only by the second
  logic [10:0]   sync2_q;       // Second stage
  logic          eor_prev_q;    // Edge detect on end of record
  logic [8:0]    rd_prev_q;     // Edge detect on read pulses

  // Command and flags
  ttc_cmd_type   cmd_q;         // Command register
  ttc_cmd_type   ld_cmd_q;      // Accumulator held between the two pulses
  logic          lcm_pend_q;    // Second pulse pending
  logic          jd_at_load_q;  // Job done as seen at the first pulse
  logic          go_q;          // Go flip-flop, low means control ready
  logic          job_done_q;
  logic          error_q;
  logic          illegal_q;
  logic          late_q;
  logic          irq_q;

  // Sequencer and datapath
  ttc_state_type state_q, state_d;
  logic [19:0]   dly_q;         // Gap or deceleration countdown
  logic [8:0]    tick_q;        // Character rate divider
  logic [1:0]    cc_q;          // Character counter
  logic [1:0]    eor_cnt_q;     // Character spaces before check character
  logic [17:0]   buf_q;         // Data buffer
  logic          buf_valid_q;   // Buffer holds a word not yet written
  logic          last_word_q;   // Word count has overflowed
  logic          dch_req_q;
  logic [17:0]   dch_rdata_q;
  logic [8:0]    wr_track_q;    // Write buffer, one flip-flop per track
  logic          write_en_q;
  logic          move_q;
  logic          rec_pulse_q;
  logic          skew_act_q;
  logic [7:0]    skew_cnt_q;
  logic [8:0]    rd_acc_q;      // Transitions gathered in the skew window
  logic [17:0]   rdata_q;

  // FSM outputs
  logic          dly_load;
  logic [19:0]   dly_val;
  logic          go_clr;
  logic          jd_set;
  logic          fsm_req;
  logic          wr_step;
  logic          eor_step;
  logic          wr_late;

  // Synchronised pins and edges
  wire           tur_s      = sync2_q[10];
  wire           eor_rise   = sync2_q[9] & ~eor_prev_q;
  wire [8:0]     rd_rise    = sync2_q[8:0] & ~rd_prev_q;

  // Register decode
  wire           wr_load    = reg_we_i && (reg_addr_i == OFS_LOAD_CMD);
  wire           wr_start   = reg_we_i && (reg_addr_i == OFS_START);
  wire           wr_clr     = reg_we_i && (reg_addr_i == OFS_CLR_FLAGS);
  wire           clear_flags_pulse   = wr_load | wr_clr;
  wire           command_load_strobe = lcm_pend_q;
  wire           clear_all  = clear_flags_pulse & ~go_q;
  // A load while busy and not done is refused and flagged
  wire           load_bad   = command_load_strobe & go_q & ~jd_at_load_q;
  wire           load_ok    = command_load_strobe & ~load_bad;

  // Legality of the loaded command, settled before start arrives
  wire           fn_ok      = (cmd_q.func == FN_READ) || (cmd_q.func == FN_WRITE);
  wire           dens_ok    = !cmd_q.nine_trk || (cmd_q.density == DENS_800);
  wire           cmd_legal  = fn_ok && dens_ok && tur_s;
  wire           go_set     = wr_start & ~go_q & cmd_legal;
  wire           start_bad  = wr_start & ~go_q & ~cmd_legal;
  wire           is_write   = (cmd_q.func == FN_WRITE);

  // Character timing and counter
  wire           char_tick  = move_q && (tick_q == CHAR_CYC - 9'h1);
  wire           dly_zero   = (dly_q == 20'h00000);
  wire           cc_last    = ttc_cc_last(cc_q, cmd_q.nine_trk);

  // Write character select, high-order group first
  wire [5:0]     six_w      = (cc_q == 2'h0) ? buf_q[17:12] :
                              (cc_q == 2'h1) ? buf_q[11:6] : buf_q[5:0];
  wire           par_w      = cmd_q.par_even ? ^six_w : ~^six_w;
  wire [8:0]     nine_w     = (cc_q == 2'h0) ? buf_q[17:9] : buf_q[8:0];
  wire [8:0]     wr_char    = cmd_q.nine_trk ? nine_w : {2'h0, par_w, six_w};

  // Read character, sampled at the end of the skew window
  wire           rd_first   = (state_q == ST_READ) && !skew_act_q && (|rd_rise);
  wire           rd_char_ok = skew_act_q && (skew_cnt_q == SKEW_CYC - 8'h01);
  wire [8:0]     rd_char    = rd_acc_q | rd_rise;
  wire [17:0]    rd_shift   = cmd_q.nine_trk ? {buf_q[8:0], rd_char} :
                              {buf_q[11:0], rd_char[5:0]};
  wire           rd_word    = rd_char_ok && cc_last;
  wire           rd_late    = rd_word && dch_req_q && !dch_ack_i;
  wire           req_set    = fsm_req | rd_word;
  wire           wr_clear   = eor_step && (eor_cnt_q == EOR_SPACE);
  wire           dch_take   = dch_ack_i && dch_req_q && is_write;

  // Status and skip words
  logic [17:0]   status_w;
  logic [17:0]   skip_w;
  always_comb
  begin
    status_w               = 18'h00000;
    status_w[ST_ERR_BIT]   = error_q;
    status_w[ST_ILL_BIT]   = illegal_q;
    status_w[ST_LATE_BIT]  = late_q;
    status_w[ST_DONE_BIT]  = job_done_q;
    status_w[ST_NINE_BIT]  = cmd_q.nine_trk;
    status_w[ST_CC_LO_BIT] = cc_q[0];
    status_w[ST_CC_HI_BIT] = cc_q[1];
    status_w[ST_GO_BIT]    = go_q;
    status_w[ST_LAST_BIT]  = last_word_q;
    skip_w                 = 18'h00000;
    skip_w[SK_DONE_BIT]    = job_done_q;
    skip_w[SK_TUR_BIT]     = tur_s;
    skip_w[SK_TCR_BIT]     = ~go_q;
    skip_w[SK_ERR_BIT]     = error_q;
  end

  // Read multiplexer; unmapped offsets read as zero
  wire [17:0]    rd_mux     = (reg_addr_i == OFS_LOAD_CMD) ? {6'h00, cmd_q} :
                              (reg_addr_i == OFS_STATUS)   ? status_w :
                              (reg_addr_i == OFS_SKIP)     ? skip_w : 18'h00000;

  // Sequencer: gap, write, end-of-record space, wait, read, deceleration
  always_comb
  begin
    state_d  = state_q;
    dly_load = 1'b0;
    dly_val  = IRG_DELAY_CYC;
    go_clr   = 1'b0;
    jd_set   = 1'b0;
    fsm_req  = 1'b0;
    wr_step  = 1'b0;
    eor_step = 1'b0;
    wr_late  = 1'b0;
    unique case (state_q)
      ST_IDLE:
        if (go_set)
        begin
          state_d  = ST_GAP;
          dly_load = 1'b1;
          fsm_req  = is_write;
        end
      ST_GAP:
        // Writing waits for the first word as well as the gap
        if (dly_zero && (!is_write || buf_valid_q))
        begin
          state_d = is_write ? ST_WRITE : ST_READ;
        end
      ST_WRITE:
        if (char_tick)
        begin
          if (!buf_valid_q)
          begin
            wr_late = 1'b1;                  // Word missed its slot: end the record
            state_d = ST_WR_EOR;
          end
          else
          begin
            wr_step = 1'b1;
            if (cc_last && last_word_q)
            begin
              state_d = ST_WR_EOR;
            end
            else if (cc_last)
            begin
              fsm_req = 1'b1;
            end
          end
        end
      ST_WR_EOR:
        if (char_tick)
        begin
          eor_step = 1'b1;
          if (eor_cnt_q == EOR_SPACE)
          begin
            state_d = ST_WAIT_EOR;
          end
        end
      ST_WAIT_EOR, ST_READ:
        if (eor_rise)
        begin
          state_d  = ST_DECEL;
          dly_load = 1'b1;
          dly_val  = DECEL_DELAY_CYC;
          jd_set   = 1'b1;
        end
      ST_DECEL:
        if (dly_zero)
        begin
          go_clr  = 1'b1;
          state_d = ST_IDLE;
        end
    endcase
  end

  // Pin synchronisers and edge history
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_q    <= 11'h000;
      sync2_q    <= 11'h000;
      eor_prev_q <= 1'b0;
      rd_prev_q  <= 9'h000;
    end
    else
    begin
      sync1_q    <= {trp_ready_i, eor_i, rd_pulse_i};
      sync2_q    <= sync1_q;
      eor_prev_q <= sync2_q[9];
      rd_prev_q  <= sync2_q[8:0];
    end
  end

  // Two-pulse command load and go flip-flop
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmd_q        <= CMD_RST;
      ld_cmd_q     <= CMD_RST;
      lcm_pend_q   <= 1'b0;
      jd_at_load_q <= 1'b0;
      go_q         <= 1'b0;
    end
    else
    begin
      lcm_pend_q <= wr_load;
      if (wr_load)
      begin
        ld_cmd_q     <= ttc_cmd_type'(reg_wdata_i[11:0]);
        jd_at_load_q <= job_done_q;
      end
      // Loading sets the unit select at once
      if (load_ok)
      begin
        cmd_q <= ld_cmd_q;
      end
      else if (clear_all)
      begin
        cmd_q <= CMD_RST;
      end
      if (go_set)
      begin
        go_q <= 1'b1;
      end
      else if (go_clr)
      begin
        go_q <= 1'b0;
      end
    end
  end

  // Flags: a hardware set in the clearing cycle wins
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      job_done_q <= 1'b0;
      error_q    <= 1'b0;
      illegal_q  <= 1'b0;
      late_q     <= 1'b0;
      irq_q      <= 1'b0;
    end
    else
    begin
      job_done_q <= jd_set | (job_done_q & ~clear_flags_pulse);
      illegal_q  <= load_bad | start_bad | (illegal_q & ~clear_flags_pulse);
      late_q     <= wr_late | rd_late | (late_q & ~clear_flags_pulse);
      error_q    <= load_bad | start_bad | wr_late | rd_late |
                    (error_q & ~clear_flags_pulse);
      irq_q      <= cmd_q.int_en & (job_done_q | error_q);
    end
  end

  // Sequencer state, delay counter and character divider
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
      dly_q   <= 20'h00000;
      tick_q  <= 9'h000;
    end
    else
    begin
      state_q <= state_d;
      dly_q   <= dly_load ? dly_val : (dly_zero ? dly_q : dly_q - 20'h00001);
      tick_q  <= (!move_q || char_tick) ? 9'h000 : tick_q + 9'h001;
    end
  end

  // Character counter, word count overflow and end-of-record spacing
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cc_q        <= 2'h0;
      eor_cnt_q   <= 2'h0;
      last_word_q <= 1'b0;
    end
    else
    begin
      if (clear_all || go_set)
      begin
        cc_q <= 2'h0;
      end
      else if (wr_step || rd_char_ok)
      begin
        cc_q <= cc_last ? 2'h0 : cc_q + 2'h1;
      end
      eor_cnt_q   <= go_set ? 2'h0 : (eor_step ? eor_cnt_q + 2'h1 : eor_cnt_q);
      last_word_q <= wc_ovf_i | (last_word_q & ~(clear_all | go_set));
    end
  end

  // Data buffer and data channel handshake
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      buf_q       <= 18'h00000;
      buf_valid_q <= 1'b0;
      dch_req_q   <= 1'b0;
      dch_rdata_q <= 18'h00000;
    end
    else
    begin
      if (clear_all)
      begin
        buf_q <= 18'h00000;
      end
      else if (dch_take)
      begin
        buf_q <= dch_wdata_i;
      end
      else if (rd_char_ok)
      begin
        buf_q <= rd_shift;
      end
      buf_valid_q <= dch_take | (buf_valid_q & ~(clear_all | (wr_step & cc_last)));
      dch_req_q   <= req_set | (dch_req_q & ~dch_ack_i & ~clear_all);
      if (rd_word)
      begin
        dch_rdata_q <= rd_shift;
      end
    end
  end

  // NRZ write buffer and transport controls
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_track_q  <= 9'h000;
      write_en_q  <= 1'b0;
      move_q      <= 1'b0;
      rec_pulse_q <= 1'b0;
    end
    else
    begin
      // A one reverses the track, a zero leaves it; parity builds up meanwhile
      if (wr_clear || clear_all)
      begin
        wr_track_q <= 9'h000;
      end
      else if (wr_step)
      begin
        wr_track_q <= wr_track_q ^ wr_char;
      end
      write_en_q  <= (state_d == ST_WRITE) || (state_d == ST_WR_EOR) ||
                     (state_d == ST_WAIT_EOR);
      move_q      <= (state_d != ST_IDLE);
      rec_pulse_q <= wr_step;
    end
  end

  // Read deskew: first transition opens the window, all tracks sampled at its end
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      skew_act_q <= 1'b0;
      skew_cnt_q <= 8'h00;
      rd_acc_q   <= 9'h000;
    end
    else if (rd_first)
    begin
      skew_act_q <= 1'b1;
      skew_cnt_q <= 8'h00;
      rd_acc_q   <= rd_rise;
    end
    else if (skew_act_q)
    begin
      skew_act_q <= !rd_char_ok;
      skew_cnt_q <= skew_cnt_q + 8'h01;
      rd_acc_q   <= rd_char_ok ? 9'h000 : rd_char;
    end
  end

  // Register read data, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= 18'h00000;
    end
    else
    begin
      rdata_q <= reg_re_i ? rd_mux : 18'h00000;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o = rdata_q;
  assign irq_o       = irq_q;
  assign dch_req_o   = dch_req_q;
  assign dch_rdata_o = dch_rdata_q;
  assign tape_o      = '{move_fwd: move_q, write_en: write_en_q, rec_pulse: rec_pulse_q,
                         unit_sel: cmd_q.unit, wr_track: wr_track_q};

endmodule : ttc_core

// file: tb/ttc_core_props.sv
// Port-level checker of the tape transport control core
module ttc_core_props #(
  parameter logic [19:0] IRG_DELAY_CYC   = ttc_pkg::IRG_DEF,
  parameter logic [19:0] DECEL_DELAY_CYC = ttc_pkg::DECEL_DEF
) (
  // Clock and reset
  input logic                      ref_clk_i,
  input logic                      rst_n_i,
  // Register port
  input logic [2:0]                reg_addr_i,
  input logic                      reg_we_i,
  input logic                      reg_re_i,
  input logic [17:0]               reg_rdata_o,
  // Data channel and transport
  input logic                      dch_req_o,
  input logic                      dch_ack_i,
  input logic [17:0]               dch_rdata_o,
  input ttc_pkg::ttc_tape_out_type tape_o
);
  import ttc_pkg::*;

  // One domain: shared clock and reset for every property
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_rdata_one_cycle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 18'h00000)
    else $error("read data outside its answer cycle");
  a_unmapped_reads: assert property ($past(reg_re_i) && $past(reg_addr_i) > OFS_SKIP |->
    reg_rdata_o == 18'h00000) else $error("unmapped read not zero");
  a_req_holds: assert property (dch_req_o && !dch_ack_i |=> dch_req_o)
    else $error("word request dropped unanswered");
  a_req_drops: assert property (dch_req_o && dch_ack_i |=> !dch_req_o)
    else $error("word request stayed after answer");
  a_rdata_steady: assert property (dch_req_o && !dch_ack_i |=> $stable(dch_rdata_o))
    else $error("read word moved while requested");
  a_unit_on_load: assert property ($changed(tape_o.unit_sel) |->
    $past(reg_we_i && reg_addr_i == OFS_LOAD_CMD, 2) ||
    $past(reg_we_i && (reg_addr_i == OFS_LOAD_CMD || reg_addr_i == OFS_CLR_FLAGS)))
    else $error("unit select moved without a load");
  a_motion_start: assert property ($rose(tape_o.move_fwd) |->
    $past(reg_we_i && reg_addr_i == OFS_START)) else $error("motion without start");
  a_rec_single: assert property (tape_o.rec_pulse |=> !tape_o.rec_pulse)
    else $error("record pulse longer than one cycle");
  a_write_moving: assert property (tape_o.write_en |-> tape_o.move_fwd)
    else $error("writing while tape not driven");
endmodule : ttc_core_props

bind ttc_core ttc_core_props #(.IRG_DELAY_CYC(IRG_DELAY_CYC), .DECEL_DELAY_CYC(DECEL_DELAY_CYC))
  props_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .dch_req_o(dch_req_o),
  .dch_ack_i(dch_ack_i), .dch_rdata_o(dch_rdata_o), .tape_o(tape_o));

// file: tb/ttc_chan_model.sv
// Processor data channel model: answers word requests after a set lag
module ttc_chan_model (
  // Clock and reset
  input  logic        ref_clk_i,
  input  logic        rst_n_i,
  // Settings from the bench
  input  logic [3:0]  lag_i,
  input  logic [17:0] word_i [4],
  input  logic [2:0]  nwords_i,
  // Data channel
  input  logic        req_i,
  output logic        ack_o,
  output logic [17:0] wdata_o,
  output logic        wc_ovf_o,
  output logic [2:0]  taken_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;  // Cycles waited on the pending request

  // One break per request; the lag lets the bench answer promptly or slowly
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      {ack_o, wc_ovf_o, taken_o, wait_q} <= '0;
      wdata_o <= 18'h15555;
    end
    else if (req_i && !ack_o && wait_q == lag_i)
    begin
      ack_o    <= 1'b1;
      wdata_o  <= word_i[taken_o[1:0]];
      wc_ovf_o <= (taken_o + 3'h1 == nwords_i);
      taken_o  <= taken_o + 3'h1;
      wait_q   <= 4'h0;
    end
    else
    begin
      ack_o    <= 1'b0;
      wc_ovf_o <= 1'b0;
      wdata_o  <= ~wdata_o;  // Undriven bus: never show a stale word
      wait_q   <= (req_i && !ack_o) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : ttc_chan_model

// file: tb/ttc_core_test.sv
// Self-checking bench of the tape transport control core
module ttc_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ttc_pkg::*;

  localparam logic [19:0] DLY = 20'h00014;  // Short gap and stop delays keep runs brief

  // Design and partner signals
  logic             ref_clk_i, rst_n_i, reg_we_i, reg_re_i, dch_ack_i, wc_ovf_i;
  logic             trp_ready_i, eor_i, irq_o, dch_req_o, rd_mode;
  logic [2:0]       reg_addr_i, nwords, unit;
  logic [17:0]      reg_wdata_i, reg_rdata_o, dch_wdata_i, dch_rdata_o, v;
  logic [17:0]      words [4];
  logic [8:0]       rd_pulse_i, trk_q, ch;
  logic [3:0]       lag;
  logic [11:0]      cmd;
  ttc_tape_out_type tape_o;
  // Bench model state
  integer           failures, tests_run, seed, i, k;
  logic [8:0]       exp_q [$];  // Characters still to be written
  logic [17:0]      rexp [$];   // Words still to be read

  ttc_core #(.IRG_DELAY_CYC(DLY), .DECEL_DELAY_CYC(DLY)) dut_u (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .dch_req_o(dch_req_o), .dch_ack_i(dch_ack_i), .dch_wdata_i(dch_wdata_i),
    .dch_rdata_o(dch_rdata_o), .wc_ovf_i(wc_ovf_i), .trp_ready_i(trp_ready_i),
    .eor_i(eor_i), .rd_pulse_i(rd_pulse_i), .tape_o(tape_o));
  ttc_chan_model chan_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .lag_i(lag),
    .word_i(words), .nwords_i(nwords), .req_i(dch_req_o), .ack_o(dch_ack_i),
    .wdata_o(dch_wdata_i), .wc_ovf_o(wc_ovf_i), .taken_o());

  // Free-running 10 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : tick

  task automatic check(input string nm, input logic [17:0] e, input logic [17:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // One-cycle write; an edge passes first so strobes never merge
  task automatic wr(input logic [2:0] a, input logic [17:0] d);
    tick(1);
    {reg_we_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    tick(1);
    reg_we_i <= 1'b0;
  endtask : wr

  // One-cycle read; data taken in the following cycle only
  task automatic rdc(input string nm, input logic [2:0] a, input logic [17:0] e, m);
    tick(1);
    {reg_re_i, reg_addr_i} <= {1'b1, a};
    tick(1);
    reg_re_i <= 1'b0;
    // Read data stand in the cycle after the strobe; look once they have settled
    #1;
    check(nm, e, reg_rdata_o & m);
  endtask : rdc

  // Peak-detector pulse on the chosen tracks
  task automatic pulse(input logic [8:0] m);
    rd_pulse_i <= m;
    tick(2);
    rd_pulse_i <= 9'h000;
    tick(10);
  endtask : pulse

  task automatic end_record;
    eor_i <= 1'b1;
    tick(4);
    eor_i <= 1'b0;
    tick(10);
  endtask : end_record

  task automatic print_verdict;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // Track model: each change is one character; once all are out, the check character
  // Sampled mid-cycle so flop outputs launched at the rising edge are settled
  always @(negedge ref_clk_i)
  begin
    if (rst_n_i && tape_o.wr_track !== trk_q)
    begin
      if (exp_q.size() > 0)
        check("char", {9'h000, exp_q.pop_front()}, {9'h000, tape_o.wr_track ^ trk_q});
      else
        check("longitudinal_check_char", 18'h00000, {9'h000, tape_o.wr_track});
    end
    if (rd_mode && dch_ack_i && rexp.size() > 0)
      check("read word", rexp.pop_front(), dch_rdata_o);
    trk_q = tape_o.wr_track;
  end

  // Hang guard
  initial
  begin
    #2000000;
    failures++;
    print_verdict();
  end

  initial
  begin
    {rst_n_i, reg_we_i, reg_re_i, eor_i, rd_mode, trp_ready_i} = '0;
    {reg_addr_i, reg_wdata_i, rd_pulse_i, trk_q, lag, nwords} = '0;
    {failures, tests_run} = '0;
    seed = 32'hAE99;
    for (i = 0; i < 4; i++)
      words[i] = 18'($random(seed));
    tick(20);
    rst_n_i <= 1'b1;
    rdc("skip idle", OFS_SKIP, 18'h00004, 18'h3FFFF);
    rdc("unmapped", 3'h7, 18'h00000, 18'h3FFFF);
    unit = 3'($random(seed));
    cmd = 12'h4C4 | {6'h00, unit, 3'h0};
    wr(OFS_LOAD_CMD, {6'h00, cmd});
    rdc("command", OFS_LOAD_CMD, {6'h00, cmd}, 18'h3FFFF);
    check("unit", {15'h0000, unit}, {15'h0000, tape_o.unit_sel});
    wr(OFS_START, 18'h00000);
    rdc("not ready", OFS_STATUS, 18'h00003, 18'h3FFFF);
    trp_ready_i <= 1'b1;
    wr(OFS_LOAD_CMD, {6'h00, cmd});
    rdc("flags cleared", OFS_STATUS, 18'h00000, 18'h3FFFF);
    rdc("skip ready", OFS_SKIP, 18'h00006, 18'h3FFFF);
    for (i = 0; i < 2; i++)
      for (k = 0; k < 3; k++)
        exp_q.push_back({2'b00, ~^words[i][17-6*k -: 6], words[i][17-6*k -: 6]});
    {lag, nwords} <= {4'hF, 3'h2};
    wr(OFS_START, 18'h00000);
    tick(3);
    check("gap request", 18'h00001, {17'h00000, dch_req_o});
    for (i = 0; i < 5000 && (exp_q.size() > 0 || tape_o.wr_track !== 9'h000); i++)
      tick(1);
    check("all written", 18'h00000, 18'(exp_q.size()));
    end_record();
    rdc("done skip", OFS_SKIP, 18'h00003, 18'h3FFFF);
    check("irq", 18'h00001, {17'h00000, irq_o});
    tick(30);
    check("stopped", 18'h00000, {17'h00000, tape_o.move_fwd});
    wr(OFS_CLR_FLAGS, 18'h00000);
    rdc("cleared", OFS_SKIP, 18'h00006, 18'h3FFFF);
    cmd = 12'h2C2 | {6'h00, unit ^ 3'h5, 3'h0};
    {lag, rd_mode} <= {4'h0, 1'b1};
    wr(OFS_LOAD_CMD, {6'h00, cmd});
    wr(OFS_START, 18'h00000);
    wr(OFS_LOAD_CMD, {6'h00, cmd ^ 12'h038});
    tick(30);
    rdc("kept command", OFS_LOAD_CMD, {6'h00, cmd}, 18'h3FFFF);
    for (i = 0; i < 4; i++)
    begin
      ch = 9'($random(seed)) | 9'h001;
      v = {v[8:0], ch};
      if (i % 2 == 1)
        rexp.push_back(v);
      pulse(ch & 9'h00F);
      pulse(ch & 9'h1F0);
      tick(290);
    end
    check("words read", 18'h00000, 18'(rexp.size()));
    end_record();
    rdc("read status", OFS_STATUS, 18'h0009B, 18'h000FF);
    check("masked irq", 18'h00000, {17'h00000, irq_o});
    print_verdict();
  end
endmodule : ttc_core_test
